// ### hw/dsw_pkg.sv
// constants and types shared by the default start watchdog
package dsw_pkg;
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] KEY_ADDR = 8'h04;
  localparam logic [3:0] STRB_BYTE0 = 4'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // mode register
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [7:0] MODE_STOP_ALL = 8'h1F;
  localparam logic [7:0] MODE_MASK = 8'h7F;
  localparam int ACT_HI = 6;
  localparam int ACT_LO = 5;
  localparam int SEL_STOP = 4;
  localparam int SEL_SUB = 3;
  localparam int SEL_N_HI = 2;
  localparam int SEL_N_LO = 0;
  // restart key register
  localparam logic [7:0] KEY_MAGIC = 8'hAC;
  localparam logic [7:0] KEY_READ = 8'h9A;
  // interval exponents
  localparam int MAIN_EXP_BASE = 18;
  localparam int SUB_EXP_BASE = 9;
  localparam int CNT_W = 26;
  localparam logic [CNT_W-1:0] CNT_ZERO = 26'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 26'h0000001;
  typedef enum logic [1:0] {
    ACT_NONE,
    ACT_NMI,
    ACT_RESET
  } dsw_action_t;
endpackage

// ### hw/dsw_counter.sv
// interval counter of the watchdog
`timescale 1ns/100ps
module dsw_counter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic clear,
  input wire logic force_ovf,
  input wire logic [dsw_pkg::CNT_W-1:0] last,
  // state
  output logic [dsw_pkg::CNT_W-1:0] count,
  output logic overflow
);
  logic [dsw_pkg::CNT_W-1:0] cnt_q;
  logic hit;

  assign hit = run && tick && (cnt_q == last);
  assign overflow = hit || force_ovf;
  assign count = cnt_q;

  // counter restarts from zero on key, mode write or overflow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= dsw_pkg::CNT_ZERO;
    end else if (clear || overflow) begin
      cnt_q <= dsw_pkg::CNT_ZERO;
    end else if (run && tick) begin
      cnt_q <= cnt_q + dsw_pkg::CNT_ONE;
    end
  end

  // a paused counter keeps its value
  hold_value_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tick && !clear && !force_ovf) |=> (cnt_q == $past(cnt_q)))
    else $error("counter moved without a tick");
endmodule

// ### hw/dsw_top.sv
// default start watchdog with an axi4-lite register slave
//
// Notes on behaviour
// - counts in reset mode right after reset
// - mode register resets to 67h
// - mode register: byte writes, one only
// - second mode write forces an overflow
// - mode field picks stop, nmi or reset
// - writing 1fh stops the watchdog for good
// - main clock interval is 2^(18+n)
// - subclock interval is 2^(9+n)
// - key acH clears and restarts the counter
// - any other key value forces overflow
// - bit access to key forces overflow
// - key register always reads 9ah
// - elapsed interval raises reset or nmi
// - no way to stop after mode write
// - main clock count halts in idle, stop
// - halt and subclock counting keep running
`timescale 1ns/100ps
module dsw_top #(
  parameter int MAIN_EXP = dsw_pkg::MAIN_EXP_BASE,
  parameter int SUB_EXP = dsw_pkg::SUB_EXP_BASE
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address
  input wire logic [dsw_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data
  input wire logic [dsw_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address
  input wire logic [dsw_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data
  output logic [dsw_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // power state and subclock
  input wire logic idle_mode,
  input wire logic stop_mode,
  input wire logic sub_tick,
  // overflow requests
  output logic watchdog_reset_request,
  output logic watchdog_nmi_request
);
  // bus state
  logic aw_full_q;
  logic w_full_q;
  logic [dsw_pkg::ADDR_W-1:0] awaddr_q;
  logic [dsw_pkg::DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [dsw_pkg::DATA_W-1:0] rdata_q;
  logic rd_key_q;
  // watchdog state
  logic [7:0] mode_q;
  logic written_q;
  logic reset_req_q;
  logic nmi_req_q;
  // decode
  logic wr_go;
  logic byte_wr;
  logic mode_wr;
  logic mode_first;
  logic mode_again;
  logic key_wr;
  logic key_ok;
  logic key_bad;
  logic force_ovf;
  logic run;
  logic tick;
  logic ovf;
  logic [dsw_pkg::CNT_W-1:0] last;
  logic [dsw_pkg::CNT_W-1:0] count;
  dsw_pkg::dsw_action_t act;

  // action selected by the two-bit mode field
  function automatic dsw_pkg::dsw_action_t action_of(input logic [7:0] m);
    if (m[dsw_pkg::ACT_HI]) begin
      return dsw_pkg::ACT_RESET;
    end else if (m[dsw_pkg::ACT_LO]) begin
      return dsw_pkg::ACT_NMI;
    end else begin
      return dsw_pkg::ACT_NONE;
    end
  endfunction

  // last count value of the selected interval
  function automatic logic [dsw_pkg::CNT_W-1:0] last_of(input logic [7:0] m);
    int shift;
    shift = int'(m[dsw_pkg::SEL_N_HI:dsw_pkg::SEL_N_LO]);
    if (m[dsw_pkg::SEL_SUB]) begin
      shift = shift + SUB_EXP;
    end else begin
      shift = shift + MAIN_EXP;
    end
    return (dsw_pkg::CNT_ONE << shift) - dsw_pkg::CNT_ONE;
  endfunction

  // read data for one address
  function automatic logic [dsw_pkg::DATA_W-1:0] read_word(
    input logic [dsw_pkg::ADDR_W-1:0] a,
    input logic [7:0] m
  );
    if (a == dsw_pkg::MODE_ADDR) begin
      return {24'h000000, m};
    end else if (a == dsw_pkg::KEY_ADDR) begin
      return {24'h000000, dsw_pkg::KEY_READ};
    end else begin
      return 32'h00000000;
    end
  endfunction

  // address and data are taken in either order
  assign awready = !aw_full_q && !bvalid_q;
  assign wready = !w_full_q && !bvalid_q;
  assign wr_go = aw_full_q && w_full_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_full_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_go) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_full_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_go) begin
      w_full_q <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= dsw_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      if (mode_wr || key_wr) begin
        bresp_q <= dsw_pkg::RESP_OKAY;
      end else if (awaddr_q == dsw_pkg::MODE_ADDR) begin
        bresp_q <= dsw_pkg::RESP_OKAY;
      end else begin
        bresp_q <= dsw_pkg::RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read answer registered, key always reads its fixed value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= dsw_pkg::RESP_OKAY;
      rdata_q <= '0;
      rd_key_q <= 1'b0;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= read_word(araddr, mode_q);
      rd_key_q <= (araddr == dsw_pkg::KEY_ADDR);
      if (araddr == dsw_pkg::MODE_ADDR || araddr == dsw_pkg::KEY_ADDR) begin
        rresp_q <= dsw_pkg::RESP_OKAY;
      end else begin
        rresp_q <= dsw_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // write decode
  assign byte_wr = (wstrb_q == dsw_pkg::STRB_BYTE0);
  assign mode_wr = wr_go && (awaddr_q == dsw_pkg::MODE_ADDR) && byte_wr;
  assign mode_first = mode_wr && !written_q;
  assign mode_again = mode_wr && written_q;
  assign key_wr = wr_go && (awaddr_q == dsw_pkg::KEY_ADDR);
  assign key_ok = key_wr && byte_wr && (wdata_q[7:0] == dsw_pkg::KEY_MAGIC);
  assign key_bad = key_wr && !key_ok;
  assign force_ovf = mode_again || key_bad;

  // mode register: reset value runs reset mode, one write allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= dsw_pkg::MODE_RESET;
      written_q <= 1'b0;
    end else if (mode_first) begin
      mode_q <= wdata_q[7:0] & dsw_pkg::MODE_MASK;
      written_q <= 1'b1;
    end
  end

  // count source and run control
  assign act = action_of(mode_q);
  assign run = (act != dsw_pkg::ACT_NONE) && !mode_q[dsw_pkg::SEL_STOP];
  assign last = last_of(mode_q);
  always_comb begin
    if (mode_q[dsw_pkg::SEL_SUB]) begin
      tick = sub_tick;
    end else begin
      tick = !(idle_mode || stop_mode);
    end
  end

  dsw_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(run),
    .tick(tick),
    .clear(key_ok || mode_first),
    .force_ovf(force_ovf),
    .last(last),
    .count(count),
    .overflow(ovf)
  );

  // overflow requests, one cycle pulses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_q <= 1'b0;
      nmi_req_q <= 1'b0;
    end else begin
      reset_req_q <= ovf && (act == dsw_pkg::ACT_RESET);
      nmi_req_q <= ovf && (act == dsw_pkg::ACT_NMI);
    end
  end
  assign watchdog_reset_request = reset_req_q;
  assign watchdog_nmi_request = nmi_req_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  mode_reset_a: assert property (disable iff (1'b0)
    !aresetn |=> (mode_q == dsw_pkg::MODE_RESET && !written_q))
    else $error("mode register not at reset value");

  auto_start_a: assert property (
    (aresetn && !written_q && count == dsw_pkg::CNT_ZERO && !idle_mode && !stop_mode
     && !force_ovf && !key_ok && !mode_first)
    |=> (count == dsw_pkg::CNT_ONE))
    else $error("watchdog did not start counting");

  write_once_a: assert property (
    written_q |=> $stable(mode_q))
    else $error("mode register changed after first write");

  second_write_a: assert property (
    (mode_again && act != dsw_pkg::ACT_NONE) |=> (reset_req_q || nmi_req_q))
    else $error("second mode write gave no overflow");

  action_match_a: assert property (
    nmi_req_q |-> $past(mode_q[dsw_pkg::ACT_HI:dsw_pkg::ACT_LO]) == 2'b01)
    else $error("nmi raised outside nmi mode");

  stop_all_a: assert property (
    (written_q && mode_q == dsw_pkg::MODE_STOP_ALL) |=> !reset_req_q && !nmi_req_q)
    else $error("stopped watchdog raised a request");

  interval_end_a: assert property (
    (run && tick && count == last && act == dsw_pkg::ACT_RESET)
    |=> reset_req_q ##1 !reset_req_q)
    else $error("interval end without one reset pulse");

  sub_interval_a: assert property (
    (mode_q[dsw_pkg::SEL_SUB] && !mode_q[dsw_pkg::SEL_STOP])
    |-> last == ((dsw_pkg::CNT_ONE << (int'(mode_q[2:0]) + SUB_EXP)) - dsw_pkg::CNT_ONE))
    else $error("subclock interval wrong");

  key_restart_a: assert property (
    key_ok |=> count == dsw_pkg::CNT_ZERO && !reset_req_q && !nmi_req_q)
    else $error("key write did not restart the count");

  bad_key_a: assert property (
    (key_bad && act == dsw_pkg::ACT_RESET) |=> reset_req_q)
    else $error("bad key access gave no reset request");

  key_read_a: assert property (
    (rvalid_q && rd_key_q) |-> rdata_q == {24'h000000, dsw_pkg::KEY_READ})
    else $error("key register read wrong value");

  no_stop_a: assert property (
    (written_q && run) |=> run)
    else $error("watchdog stopped after mode write");

  idle_hold_a: assert property (
    (!mode_q[dsw_pkg::SEL_SUB] && (idle_mode || stop_mode) && !force_ovf && !key_ok
     && !mode_first) |=> $stable(count))
    else $error("main clock count moved in idle or stop");
endmodule

// ### sim/tb_dsw_top.sv
// self-checking bench for the default start watchdog
`timescale 1ns/100ps
module tb_dsw_top;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} dsw_rd_row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic idle_mode, stop_mode, sub_tick, sub_en;
  logic awready, wready, bvalid, arready, rvalid;
  logic watchdog_reset_request, watchdog_nmi_request;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int miscompares, check_count, rc, nc, cyc, sc;
  dsw_rd_row_t rows [4];

  dsw_top #(.MAIN_EXP(2), .SUB_EXP(1)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .sub_tick(sub_tick), .watchdog_reset_request(watchdog_reset_request),
    .watchdog_nmi_request(watchdog_nmi_request));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // pulse counters and hang guard, sampled away from the active edge
  always @(negedge aclk) begin
    cyc++;
    if (watchdog_reset_request === 1'b1) rc++;
    if (watchdog_nmi_request === 1'b1) nc++;
    if (cyc > 8000) begin
      miscompares++;
      give_verdict();
    end
  end

  // subclock tick every eighth cycle while enabled
  always @(posedge aclk) begin
    sc <= (sc + 1) % 8;
    sub_tick <= sub_en && (sc == 0);
  end

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    check_count++;
    if (g != e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc = 0;
    nc = 0;
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    idle_mode = 1'b0;
    stop_mode = 1'b0;
    sub_en = 1'b0;
    cyc = 0;
    miscompares = 0;
    check_count = 0;
    rows[0] = '{dsw_pkg::MODE_ADDR, 32'h00000067, dsw_pkg::RESP_OKAY};
    rows[1] = '{dsw_pkg::KEY_ADDR, 32'h0000009A, dsw_pkg::RESP_OKAY};
    rows[2] = '{8'h08, 32'h00000000, dsw_pkg::RESP_SLVERR};
    rows[3] = '{8'hFC, 32'h00000000, dsw_pkg::RESP_SLVERR};
    do_reset();
    repeat (500) @(posedge aclk);
    chk_cnt("early_reset", 0, rc);
    repeat (20) @(posedge aclk);
    chk_cnt("reset_pulse", 1, rc);
    chk_cnt("nmi_pulse", 0, nc);
    foreach (rows[i]) begin
      rdr(rows[i].a, rd, rs);
      chk_val("read_data", rows[i].d, rd);
      chk_val("read_resp", {30'h0, rows[i].r}, {30'h0, rs});
    end
    wr(8'h10, 8'h00, dsw_pkg::STRB_BYTE0, rs);
    chk_val("unmapped_wr", {30'h0, dsw_pkg::RESP_SLVERR}, {30'h0, rs});
    // restart keys hold off the overflow, misuse forces one
    do_reset();
    wr(dsw_pkg::MODE_ADDR, 8'h1F, 4'h3, rs);
    chk_val("mode_wide_resp", {30'h0, dsw_pkg::RESP_OKAY}, {30'h0, rs});
    rdr(dsw_pkg::MODE_ADDR, rd, rs);
    chk_val("mode_wide_wr", 32'h00000067, rd);
    repeat (4) begin
      repeat (400) @(posedge aclk);
      wr(dsw_pkg::KEY_ADDR, dsw_pkg::KEY_MAGIC, dsw_pkg::STRB_BYTE0, rs);
    end
    chk_cnt("key_restart", 0, rc);
    wr(dsw_pkg::KEY_ADDR, 8'h55, dsw_pkg::STRB_BYTE0, rs);
    repeat (2) @(posedge aclk);
    chk_cnt("bad_key", 1, rc);
    wr(dsw_pkg::KEY_ADDR, dsw_pkg::KEY_MAGIC, 4'h3, rs);
    repeat (2) @(posedge aclk);
    chk_cnt("bit_key", 2, rc);
    // nmi mode with bit 7 dropped, then a second mode write
    do_reset();
    wr(dsw_pkg::MODE_ADDR, 8'hA7, dsw_pkg::STRB_BYTE0, rs);
    repeat (100) @(posedge aclk);
    chk_cnt("nmi_early", 0, nc);
    wr(dsw_pkg::MODE_ADDR, dsw_pkg::MODE_STOP_ALL, dsw_pkg::STRB_BYTE0, rs);
    repeat (2) @(posedge aclk);
    chk_cnt("second_mode", 1, nc);
    rdr(dsw_pkg::MODE_ADDR, rd, rs);
    chk_val("mode_kept", 32'h00000027, rd);
    repeat (600) @(posedge aclk);
    chk_cnt("nmi_cont", 2, nc);
    chk_cnt("no_reset", 0, rc);
    // full stop
    do_reset();
    wr(dsw_pkg::MODE_ADDR, dsw_pkg::MODE_STOP_ALL, dsw_pkg::STRB_BYTE0, rs);
    repeat (1100) @(posedge aclk);
    wr(dsw_pkg::KEY_ADDR, 8'h55, dsw_pkg::STRB_BYTE0, rs);
    repeat (2) @(posedge aclk);
    chk_cnt("stopped", 0, rc + nc);
    // clock field top bit stops counting, misuse still forces the action
    do_reset();
    wr(dsw_pkg::MODE_ADDR, 8'h50, dsw_pkg::STRB_BYTE0, rs);
    repeat (600) @(posedge aclk);
    chk_cnt("clock_stop", 0, rc);
    wr(dsw_pkg::KEY_ADDR, 8'h55, dsw_pkg::STRB_BYTE0, rs);
    repeat (2) @(posedge aclk);
    chk_cnt("clock_stop_force", 1, rc);
    // subclock counting runs in stop mode
    stop_mode <= 1'b1;
    do_reset();
    wr(dsw_pkg::MODE_ADDR, 8'h48, dsw_pkg::STRB_BYTE0, rs);
    repeat (200) @(posedge aclk);
    chk_cnt("sub_wait", 0, rc);
    sub_en <= 1'b1;
    repeat (40) @(posedge aclk);
    chk_cnt("sub_run", 1, int'(rc > 0));
    // main clock count holds in idle
    sub_en <= 1'b0;
    stop_mode <= 1'b0;
    idle_mode <= 1'b1;
    do_reset();
    wr(dsw_pkg::MODE_ADDR, 8'h40, dsw_pkg::STRB_BYTE0, rs);
    repeat (200) @(posedge aclk);
    chk_cnt("idle_hold", 0, rc);
    idle_mode <= 1'b0;
    repeat (10) @(posedge aclk);
    chk_cnt("idle_left", 1, int'(rc > 0));
    give_verdict();
  end
endmodule
